// *** sfur_dev.sv ***
// Device end: answers the table read and unique-number read opcode.
// Assumes link pins are asynchronous to core_clk and the link clock
// runs well below a quarter of the core clock rate.
`timescale 1ns/100ps
module sfur_dev #(
  // Per-die number; value is arbitrary
  parameter logic [95:0] UID = 96'h0123_4567_89ab_cdef_0f1e_2d3c
) (
  input  wire logic core_clk,
  input  wire logic rst_n,
  sfur_link_if.dev  link,
  input  wire logic wr_busy,
  output logic      xfer_active,
  output logic      rejected
);

  // All state of the device end
  typedef struct packed {
    logic [2:0]             clk_s;  // Link clock: sync 1, sync 2, previous
    logic [1:0]             cs_s;   // Chip select synchroniser
    logic [1:0]             si_s;   // Input line synchroniser
    sfur_pkg::sfur_dev_st_t st;     // Transfer phase
    logic [4:0]             bcnt;   // Bits taken or left in a field
    logic [7:0]             op;     // Opcode being shifted in
    logic [23:0]            addr;   // Byte address
    logic [7:0]             sh;     // Output byte shifter
    logic                   so;     // Output line value
    logic                   oe;     // Output line enable
    logic                   act;    // Selected flag
    logic                   rej;    // Rejection pulse
  } sfur_dev_state_t;

  // Idle values; the line is released and inputs read idle
  localparam sfur_dev_state_t RST_STATE = '{
    clk_s: 3'h0,
    cs_s:  2'h3,
    si_s:  2'h0,
    st:    sfur_pkg::DS_IDLE,
    bcnt:  5'h00,
    op:    8'h00,
    addr:  24'h000000,
    sh:    8'h00,
    so:    1'b1,
    oe:    1'b0,
    act:   1'b0,
    rej:   1'b0
  };

  sfur_dev_state_t q;      // Registered state
  sfur_dev_state_t d;      // Next state
  logic            rise;   // Link clock rising, seen late by two cycles
  logic            fall;   // Link clock falling
  logic            cs_hi;  // Chip select deasserted
  logic            si_b;   // Synchronised input bit
  logic [7:0]      rom_b;  // Byte at the current address
  logic [7:0]      op_n;   // Opcode with the newest bit

  // Table and unique number lookup
  sfur_rom #(
    .UID (UID)
  ) sfur_rom_i (
    .addr (q.addr),
    .data (rom_b)
  );

  // Edge detection uses only second-stage and later flops, so a
  // metastable first stage never reaches any logic.
  assign rise  = q.clk_s[1] & ~q.clk_s[2];
  assign fall  = ~q.clk_s[1] & q.clk_s[2];
  assign cs_hi = q.cs_s[1];
  // Clock and data share the same delay, so the bit is aligned
  assign si_b  = q.si_s[1];
  assign op_n  = {q.op[6:0], si_b};

  // Next-state logic
  always_comb begin
    d       = q;
    d.rej   = 1'b0;
    // Two-flop synchronisers for every link input
    d.clk_s = {q.clk_s[1], q.clk_s[0], link.sclk};
    d.cs_s  = {q.cs_s[0], link.cs_n};
    d.si_s  = {q.si_s[0], link.si};
    if (cs_hi) begin
      // Deselect ends any phase and releases the line at once
      d.st  = sfur_pkg::DS_IDLE;
      d.oe  = 1'b0;
      d.so  = 1'b1;
      d.act = 1'b0;
    end else begin
      case (q.st)
        sfur_pkg::DS_IDLE: begin
          // Newly selected; the first rise is still ahead
          d.st   = sfur_pkg::DS_CMD;
          d.bcnt = 5'h00;
          d.act  = 1'b1;
        end
        sfur_pkg::DS_CMD: begin
          // Opcode, most significant bit first
          if (rise) begin
            d.op   = op_n;
            d.bcnt = q.bcnt + 5'h01;
            if (q.bcnt == sfur_pkg::OPC_BITS - 5'h01) begin
              d.bcnt = 5'h00;
              if (op_n == sfur_pkg::OPC_PARAM_RD && !wr_busy) begin
                d.st = sfur_pkg::DS_ADDR;
              end else begin
                // Other opcode or busy write cycle: drop the read, touch nothing else
                d.st  = sfur_pkg::DS_IGN;
                d.rej = (op_n == sfur_pkg::OPC_PARAM_RD);
              end
            end
          end
        end
        sfur_pkg::DS_ADDR: begin
          // Three address bytes, most significant bit first
          if (rise) begin
            d.addr = {q.addr[22:0], si_b};
            d.bcnt = q.bcnt + 5'h01;
            if (q.bcnt == sfur_pkg::ADDR_BITS - 5'h01) begin
              d.st   = sfur_pkg::DS_DUMMY;
              d.bcnt = 5'h00;
            end
          end
        end
        sfur_pkg::DS_DUMMY: begin
          // Dummy byte content is ignored
          if (rise) begin
            d.bcnt = q.bcnt + 5'h01;
            if (q.bcnt == sfur_pkg::DUMMY_BITS - 5'h01) begin
              d.st   = sfur_pkg::DS_DATA;
              d.bcnt = 5'h00;
            end
          end
        end
        sfur_pkg::DS_DATA: begin
          // Output changes only on falls, so the host samples
          // a stable bit on the following fall.
          if (fall) begin
            d.oe = 1'b1;
            if (q.bcnt == 5'h00) begin
              // Start of a byte: fetch it and move the address on.
              // The 24-bit counter wraps from its top to zero.
              d.so   = rom_b[7];
              d.sh   = {rom_b[6:0], 1'b0};
              d.addr = q.addr + 24'h000001;
              d.bcnt = sfur_pkg::BYTE_BITS - 5'h01;
            end else begin
              d.so   = q.sh[7];
              d.sh   = {q.sh[6:0], 1'b0};
              d.bcnt = q.bcnt - 5'h01;
            end
          end
        end
        sfur_pkg::DS_IGN: begin
          // Wait for deselect; the line stays released
          d.oe = 1'b0;
        end
        default: begin
          d.st = sfur_pkg::DS_IDLE;
        end
      endcase
    end
  end

  // State register with synchronous reset
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      q <= RST_STATE;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from flops
  assign link.so_o  = q.so;
  assign link.so_oe = q.oe;
  assign xfer_active = q.act;
  assign rejected    = q.rej;

endmodule

// *** sfur_pkg.sv ***
// Shared constants and types for the parameter-table reader link.
// Assumes both ends run on one 25 MHz core clock.
package sfur_pkg;

  // Core clock period, ns
  localparam int CLK_NS = 40;
  // Default link clock period made by the host, ns
  localparam int SCLK_NS = 320;
  // Host half period in core cycles, rounded down, never below one
  localparam int SCLK_HALF_CYC = (SCLK_NS / 2 / CLK_NS < 1) ? 1 : SCLK_NS / 2 / CLK_NS;

  // Shared opcode of table read and unique-number read
  localparam logic [7:0] OPC_PARAM_RD = 8'h5a;
  // Dummy byte value sent by the host
  localparam logic [7:0] DUMMY_BYTE = 8'h00;
  // Field lengths in link clocks
  localparam logic [4:0] OPC_BITS   = 5'h08;
  localparam logic [4:0] ADDR_BITS  = 5'h18;
  localparam logic [4:0] DUMMY_BITS = 5'h08;
  localparam logic [4:0] BYTE_BITS  = 5'h08;
  // Whole header: opcode, address and dummy
  localparam logic [5:0] HDR_BITS = 6'h28;

  // Table layout
  localparam logic [23:0] TBL_LAST  = 24'h000053;
  localparam logic [23:0] UID_BASE  = 24'h000080;
  localparam logic [23:0] UID_LAST  = 24'h00008b;
  localparam logic [7:0]  FILL_BYTE = 8'hff;
  localparam int          TBL_LEN   = 84;

  // Table contents, byte 00h first
  localparam logic [7:0] TABLE [0:TBL_LEN-1] = '{
    8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01, 8'h00, 8'hff,
    8'h00, 8'h00, 8'h01, 8'h09, 8'h30, 8'h00, 8'h00, 8'hff,
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
    8'hed, 8'h20, 8'hf1, 8'hff, 8'hff, 8'hff, 8'hff, 8'h01,
    8'h44, 8'heb, 8'h08, 8'h6b, 8'h08, 8'h3b, 8'h04, 8'hbb,
    8'hfe, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00, 8'hff,
    8'hff, 8'hff, 8'h44, 8'heb, 8'h0c, 8'h20, 8'h0f, 8'h52,
    8'h10, 8'hd8, 8'h00, 8'hff
  };

  // Device end states
  typedef enum logic [5:0] {
    DS_IDLE  = 6'h01,
    DS_CMD   = 6'h02,
    DS_ADDR  = 6'h04,
    DS_DUMMY = 6'h08,
    DS_DATA  = 6'h10,
    DS_IGN   = 6'h20
  } sfur_dev_st_t;

  // Host end states
  typedef enum logic [3:0] {
    HS_IDLE = 4'h1,
    HS_HDR  = 4'h2,
    HS_DATA = 4'h4,
    HS_FIN  = 4'h8
  } sfur_host_st_t;

endpackage

// *** sfur_link_if.sv ***
// Serial link between host controller and flash parameter reader.
// Assumes the testbench instantiates it and joins both ends.
`timescale 1ns/100ps
interface sfur_link_if;
  logic sclk;   // Serial clock, made by host
  logic cs_n;   // Chip select, low active
  logic si;     // Serial data into device
  logic so_o;   // Device output value
  logic so_oe;  // Device drives output line
  logic so;     // Resolved output line

  // Undriven line reads high, as with a pull-up
  assign so = so_oe ? so_o : 1'b1;

  modport dev  (input sclk, input cs_n, input si, output so_o, output so_oe);
  modport host (output sclk, output cs_n, output si, input so);
endinterface

// *** sfur_rom.sv ***
// Byte lookup for the parameter address space and unique number.
// Assumes a 24-bit byte address from the device end.
`timescale 1ns/100ps
module sfur_rom #(
  // Per-die number; value is arbitrary
  parameter logic [95:0] UID = 96'h0123_4567_89ab_cdef_0f1e_2d3c
) (
  input  wire logic [23:0] addr,
  output logic      [7:0]  data
);
  logic [23:0] uid_off;  // Offset into unique number

  // Table bytes, then unique number, FFh elsewhere
  always_comb begin
    uid_off = addr - sfur_pkg::UID_BASE;
    if (addr <= sfur_pkg::TBL_LAST) begin
      // Also density, fast read, erase and reserved bytes
      // Multi-line reads and erase types; reserved bits read one
      data = sfur_pkg::TABLE[addr[6:0]];
    end else if (addr >= sfur_pkg::UID_BASE && addr <= sfur_pkg::UID_LAST) begin
      // Lowest byte of the number sits at the base address
      data = UID[{uid_off[3:0], 3'h0} +: 8];
    end else begin
      data = sfur_pkg::FILL_BYTE;
    end
  end
endmodule

// *** sfur_host.sv ***
// Host end: makes the link clock and reads a run of table bytes.
// Assumes the device answers on the link; the host samples each bit
// at the next falling edge, late enough for the device sync delay.
`timescale 1ns/100ps
module sfur_host #(
  // Core cycles per link clock half period; at least three
  parameter int HALF_CYC = sfur_pkg::SCLK_HALF_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  sfur_link_if.host        link,
  input  wire logic        start,
  input  wire logic [23:0] start_addr,
  input  wire logic [15:0] byte_count,
  output logic             busy,
  output logic [7:0]       rd_data,
  output logic             rd_valid,
  output logic             done
);

  localparam logic [7:0] HALF_LAST = 8'(HALF_CYC - 1);  // Divider top

  // All state of the host end
  typedef struct packed {
    sfur_pkg::sfur_host_st_t st;    // Phase
    logic [7:0]              div;   // Half-period divider
    logic                    sclk;  // Link clock
    logic                    cs_n;  // Chip select
    logic                    si;    // Data to device
    logic [39:0]             tx;    // Header shifter
    logic [5:0]              bitn;  // Header bits left
    logic [7:0]              rx;    // Incoming byte
    logic [2:0]              rcnt;  // Bits of the byte taken
    logic [15:0]             left;  // Bytes still wanted
    logic [1:0]              so_s;  // Output line synchroniser
    logic [7:0]              rd;    // Delivered byte
    logic                    rv;    // Byte pulse
    logic                    dn;    // End pulse
  } sfur_host_state_t;

  localparam sfur_host_state_t RST_STATE = '{
    st: sfur_pkg::HS_IDLE, div: 8'h00, sclk: 1'b0, cs_n: 1'b1, si: 1'b0,
    tx: 40'h0, bitn: 6'h00, rx: 8'h00, rcnt: 3'h0, left: 16'h0000,
    so_s: 2'h3, rd: 8'h00, rv: 1'b0, dn: 1'b0
  };

  sfur_host_state_t q;     // Registered state
  sfur_host_state_t d;     // Next state
  logic             tick;  // Half period elapsed
  logic [7:0]       rx_n;  // Byte with newest bit

  assign tick = (q.div == HALF_LAST);
  assign rx_n = {q.rx[6:0], q.so_s[1]};

  // Next-state logic; clock idles low between frames
  always_comb begin
    d      = q;
    d.rv   = 1'b0;
    d.dn   = 1'b0;
    d.so_s = {q.so_s[0], link.so};
    if (q.st != sfur_pkg::HS_IDLE) begin
      d.div = tick ? 8'h00 : q.div + 8'h01;
    end
    case (q.st)
      sfur_pkg::HS_IDLE: begin
        if (start) begin
          // Header leaves most significant bit first
          d.tx   = {sfur_pkg::OPC_PARAM_RD, start_addr, sfur_pkg::DUMMY_BYTE};
          d.si   = sfur_pkg::OPC_PARAM_RD[7];
          d.cs_n = 1'b0;
          d.bitn = sfur_pkg::HDR_BITS - 6'h01;
          d.left = byte_count;
          d.div  = 8'h00;
          d.st   = sfur_pkg::HS_HDR;
        end
      end
      sfur_pkg::HS_HDR: begin
        if (tick) begin
          d.sclk = ~q.sclk;
          // Input line changes on falls, device takes it on rises
          if (q.sclk) begin
            if (q.bitn == 6'h00) begin
              d.st   = sfur_pkg::HS_DATA;
              d.rcnt = 3'h0;
            end else begin
              d.tx   = {q.tx[38:0], 1'b0};
              d.si   = q.tx[38];
              d.bitn = q.bitn - 6'h01;
            end
          end
        end
      end
      sfur_pkg::HS_DATA: begin
        if (tick) begin
          d.sclk = ~q.sclk;
          // Bit driven at the last fall is stable by this fall
          if (q.sclk) begin
            d.rx   = rx_n;
            d.rcnt = q.rcnt + 3'h1;
            if (q.rcnt == 3'h7) begin
              d.rd   = rx_n;
              d.rv   = 1'b1;
              d.left = q.left - 16'h0001;
              if (q.left == 16'h0001) begin
                // Deselect may come at any point of the output
                d.cs_n = 1'b1;
                d.st   = sfur_pkg::HS_FIN;
              end
            end
          end
        end
      end
      sfur_pkg::HS_FIN: begin
        // Hold deselect for one half period before the next frame
        if (tick) begin
          d.st = sfur_pkg::HS_IDLE;
          d.dn = 1'b1;
        end
      end
      default: begin
        d = RST_STATE;
      end
    endcase
  end

  // State register with synchronous reset
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      q <= RST_STATE;
    end else begin
      q <= d;
    end
  end

  assign link.sclk = q.sclk;
  assign link.cs_n = q.cs_n;
  assign link.si   = q.si;
  assign busy      = (q.st != sfur_pkg::HS_IDLE);
  assign rd_data   = q.rd;
  assign rd_valid  = q.rv;
  assign done      = q.dn;

endmodule

// *** sfur_link_checker.sv ***
// Checker for the serial link joining host end and parameter reader.
// Assumes the bench instantiates it beside the link interface.
`timescale 1ns/100ps
module sfur_link_checker (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic si,
  input wire logic so_o,
  input wire logic so_oe,
  input wire logic so
);
  logic       sclk_q;  // Link clock one cycle back
  logic [5:0] rise_q;  // Rises seen in this frame, saturating

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // Count link clock rises per frame; saturates so long frames never wrap
  always_ff @(posedge core_clk) begin
    sclk_q <= sclk;
    if (!rst_n || cs_n) begin
      rise_q <= 6'h00;
    end else if (sclk && !sclk_q && rise_q != 6'h3f) begin
      rise_q <= rise_q + 6'h01;
    end
  end

  a_cs_setup_low: assert property ($fell(cs_n) |-> !sclk [*3])
    else $error("link clock rose too soon after select");
  a_si_on_fall: assert property ($changed(si) && !cs_n |-> !sclk)
    else $error("input bit moved while clock high");
  a_clk_high_span: assert property ($rose(sclk) |-> sclk [*3])
    else $error("link clock high phase too short");
  a_out_on_fall: assert property ($changed(so_o) && so_oe |-> !sclk)
    else $error("output bit moved while clock high");
  a_oe_after_hdr: assert property ($rose(so_oe) |-> !cs_n && rise_q == 6'h28)
    else $error("output enabled before or after header end");
  a_out_data_only: assert property (so_oe && !cs_n |-> rise_q >= 6'h28)
    else $error("output driven during header");
  a_drive_ends: assert property ($rose(cs_n) |-> ##[1:3] !so_oe)
    else $error("output not released after deselect");
  a_line_idle: assert property (cs_n [*4] |-> so && !so_oe)
    else $error("line not released while deselected");
endmodule

// *** testbench.sv ***
// Self-checking bench: host end reads table and die number from device.
// Assumes both ends share core_clk and meet in the link interface.
`timescale 1ns/100ps
module testbench;
  // Die number for the device; value is arbitrary
  localparam logic [95:0] TB_UID = 96'h5a3c_96e1_0f2d_4b87_c3a5_e178;
  // Expected table, byte 00h leftmost
  localparam logic [0:83][7:0] EXP_TBL = {128'h53464450000100ff_00000109300000ff,
    {32{8'hff}}, 288'hed20f1ffffffff01_44eb086b083b04bb_feffffffffff00ff_ffff44eb0c200f52_10d800ff};

  logic        core_clk;     // 25 MHz core clock
  logic        rst_n;        // Sync reset, low active
  logic        start;        // Host start pulse
  logic [23:0] start_addr;   // First byte address
  logic [15:0] byte_count;   // Bytes to read
  logic        busy;         // Host busy
  logic [7:0]  rd_data;      // Byte received
  logic        rd_valid;     // Byte strobe
  logic        done;         // Frame finished
  logic        wr_busy;      // Write cycle in progress
  logic        xfer_active;  // Device sees select
  logic        rejected;     // Device refused opcode
  logic [7:0]  got[$];       // Bytes of last frame
  logic        saw_rej;      // Refusal seen in frame
  logic        saw_oe;       // Output enable seen in frame
  logic        saw_act;      // Device select seen in frame
  int          n_fail;       // Mismatch count
  int          comparisons;  // Comparison count

  sfur_link_if sfur_link_if_i ();

  sfur_dev #(.UID(TB_UID)) sfur_dev_i (
    .core_clk    (core_clk),
    .rst_n       (rst_n),
    .link        (sfur_link_if_i.dev),
    .wr_busy     (wr_busy),
    .xfer_active (xfer_active),
    .rejected    (rejected)
  );

  sfur_host sfur_host_i (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .link       (sfur_link_if_i.host),
    .start      (start),
    .start_addr (start_addr),
    .byte_count (byte_count),
    .busy       (busy),
    .rd_data    (rd_data),
    .rd_valid   (rd_valid),
    .done       (done)
  );

  sfur_link_checker sfur_link_checker_i (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .sclk     (sfur_link_if_i.sclk),
    .cs_n     (sfur_link_if_i.cs_n),
    .si       (sfur_link_if_i.si),
    .so_o     (sfur_link_if_i.so_o),
    .so_oe    (sfur_link_if_i.so_oe),
    .so       (sfur_link_if_i.so)
  );

  // Core clock, 40 ns period
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // Print counts and verdict, then stop
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // One byte comparison
  task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  // One host read; samples at falling core edges so flops have settled
  task automatic run(input logic [23:0] a, input logic [15:0] n);
    int w;
    got.delete();
    saw_rej = 1'b0;
    saw_oe = 1'b0;
    saw_act = 1'b0;
    w = 0;
    @(posedge core_clk);
    #1 start = 1'b1;
    start_addr = a;
    byte_count = n;
    @(posedge core_clk);
    #1 start = 1'b0;
    chk({7'h00, busy}, 8'h01, "host not busy after start");
    while (done !== 1'b1 && w < 20000) begin
      @(negedge core_clk);
      w++;
      if (rd_valid === 1'b1) got.push_back(rd_data);
      if (rejected === 1'b1) saw_rej = 1'b1;
      if (sfur_link_if_i.so_oe !== 1'b0) saw_oe = 1'b1;
      if (xfer_active === 1'b1) saw_act = 1'b1;
    end
    chk({7'h00, done}, 8'h01, "frame did not finish");
    chk(8'(got.size()), n[7:0], "byte count");
    chk({7'h00, saw_act}, 8'h01, "device never selected");
    chk({7'h00, busy}, 8'h00, "host busy after done");
    chk({7'h00, xfer_active}, 8'h00, "device still selected");
    chk({7'h00, sfur_link_if_i.so_oe}, 8'h00, "line driven after deselect");
  endtask

  // Whole table streamed from address zero
  task automatic t_table();
    run(24'h000000, 16'h0054);
    for (int i = 0; i < 84; i++) begin
      chk(got[i], EXP_TBL[i], "table byte");
    end
    $display("test table done");
  endtask

  // Die number framed by undefined bytes
  task automatic t_uid();
    logic [7:0] e;
    int         a;
    run(24'h00007e, 16'h0010);
    for (int i = 0; i < 16; i++) begin
      a = 32'h0000007e + i;
      e = (a >= 32'h00000080 && a <= 32'h0000008b) ? TB_UID[8*(a-32'h00000080) +: 8] : 8'hff;
      chk(got[i], e, "unique number byte");
    end
    // Read started exactly at the die number base
    run(24'h000080, 16'h000c);
    for (int i = 0; i < 12; i++) begin
      chk(got[i], TB_UID[8*i +: 8], "die number from base");
    end
    $display("test uid done");
  endtask

  // Counter wraps from the highest address to zero
  task automatic t_wrap();
    logic [7:0] e[4];
    e = '{8'hff, 8'hff, 8'h53, 8'h46};
    run(24'hfffffe, 16'h0004);
    for (int i = 0; i < 4; i++) begin
      chk(got[i], e[i], "wrap byte");
    end
    $display("test wrap done");
  endtask

  // Read during a write cycle is refused; released line reads high
  task automatic t_reject();
    @(posedge core_clk);
    #1 wr_busy = 1'b1;
    run(24'h000000, 16'h0002);
    @(posedge core_clk);
    #1 wr_busy = 1'b0;
    chk({7'h00, saw_rej}, 8'h01, "no refusal pulse");
    chk({7'h00, saw_oe}, 8'h00, "output driven when refused");
    chk(got[0], 8'hff, "refused byte");
    run(24'h000004, 16'h0002);
    chk(got[0], 8'h00, "first byte after refusal");
    chk(got[1], 8'h01, "read after refusal");
    $display("test reject done");
  endtask

  // Main sequence
  initial begin
    n_fail = 0;
    comparisons = 0;
    rst_n = 1'b0;
    start = 1'b0;
    start_addr = 24'h000000;
    byte_count = 16'h0000;
    wr_busy = 1'b0;
    repeat (3) @(posedge core_clk);
    #1 rst_n = 1'b1;
    t_table();
    t_uid();
    t_wrap();
    t_reject();
    close_out();
  end

  // Watchdog; all tests need about 0.4 ms, well under two milliseconds
  initial begin
    #2ms;
    n_fail++;
    $display("ERROR %0t watchdog expired", $time);
    close_out();
  end
endmodule
